// ==== rdc_defines.svh ====
// register indices, field positions, codes and timing counts of the rx command block
// assumes a 40 MHz clock and an APB bus whose byte address is four times the index
`ifndef RDC_DEFINES_SVH
`define RDC_DEFINES_SVH

// register indices; byte address is index * 4
`define RDC_IDX_CMD 6'h01
`define RDC_IDX_OP_CTRL 6'h02
`define RDC_IDX_MODE 6'h03
`define RDC_IDX_BITRATE 6'h04
`define RDC_IDX_AUX 6'h09
`define RDC_IDX_RC1 6'h0A
`define RDC_IDX_RC3 6'h0C
`define RDC_IDX_RC4 6'h0D
`define RDC_IDX_ADC 6'h11
`define RDC_IDX_STAT 6'h12

// reset values
`define RDC_RST_OP_CTRL 8'h00
`define RDC_RST_MODE 8'h00
`define RDC_RST_BITRATE 8'h00
`define RDC_RST_AUX 8'h00
`define RDC_RST_RC1 8'h00
`define RDC_RST_RC3 8'h00
`define RDC_RST_RC4 8'h00

// operation control fields
`define RDC_OP_EN 7
`define RDC_OP_RX_EN 6
`define RDC_OP_RX_CHN 5
`define RDC_OP_TX_EN 3
// auxiliary definition fields
`define RDC_AUX_TX_MOD_TYPE 5
`define RDC_AUX_FIELD_DET_ON 4
// receiver configuration one fields
`define RDC_RC1_CHANNEL 7
`define RDC_RC1_AM_DEMOD 6
`define RDC_RC1_LP_HI 5
`define RDC_RC1_LP_LO 3
`define RDC_RC1_ZERO_HI 2
`define RDC_RC1_ZERO_LO 0
// receiver configuration three fields
`define RDC_RC3_CLIP 1
`define RDC_RC3_FORCED_GAIN 0
// mode definition: bit 7 marks a target mode, bits 2:0 the protocol
`define RDC_MODE_TARGET 7
`define RDC_MODE_ISOA 3'h0
`define RDC_MODE_ISOB 3'h1
`define RDC_MODE_TYPEF 3'h2
`define RDC_MODE_NFC_INIT 3'h3
`define RDC_MODE_VICINITY 3'h4
`define RDC_MODE_NFC_TGT 3'h5
`define RDC_MODE_SUBC_STREAM 3'h6
`define RDC_MODE_BPSK_STREAM 3'h7
// bit rate definition: tx in 5:4, rx in 1:0
`define RDC_RATE_106 2'h0
`define RDC_RATE_212 2'h1
`define RDC_RATE_424 2'h2
`define RDC_RATE_848 2'h3
// low pass and zero setting choices
`define RDC_LP_106 3'h0
`define RDC_LP_212 3'h1
`define RDC_LP_424 3'h2
`define RDC_LP_848 3'h4
`define RDC_LP_VICINITY 3'h5
`define RDC_ZERO_SUBC 3'h6
`define RDC_ZERO_848 3'h3
`define RDC_ZERO_DEFAULT 3'h0
// direct command codes
`define RDC_CMD_PRESET 8'hCC
`define RDC_CMD_MASK 8'hD0
`define RDC_CMD_UNMASK 8'hD1
`define RDC_CMD_MEAS_AMP 8'hD3
`define RDC_CMD_SQUELCH 8'hD4
`define RDC_CMD_GAIN_RST 8'hD5
// status fields
`define RDC_STAT_MEAS_BUSY 0
`define RDC_STAT_SQUELCH 1
`define RDC_STAT_RX_ON 2
`define RDC_STAT_MASK_CMD 3
// amplitude scale: micro volt peak-peak per count, full scale code
`define RDC_AMPL_LSB_UVPP 13020
`define RDC_AMPL_FULL_CODE 8'hE6
// timing
`define RDC_CLK_PERIOD_NS 25
`define RDC_MEAS_MAX_NS 25000
`define RDC_MEAS_CYC (`RDC_MEAS_MAX_NS / `RDC_CLK_PERIOD_NS)
`define RDC_SQUELCH_MAX_NS 500000
`define RDC_SQUELCH_CYC (`RDC_SQUELCH_MAX_NS / `RDC_CLK_PERIOD_NS)

`endif

// ==== rdc_pkg.sv ====
// types shared by the rx command block
// assumes rdc_defines.svh for all numeric values
package rdc_pkg;

  typedef enum logic [1:0] {
    RDC_ST_IDLE,
    RDC_ST_MEAS_WAIT,
    RDC_ST_SQUELCH
  } rdc_state_t;

  // values loaded by the analog preset command
  typedef struct packed {
    logic [7:0] op_ctrl;
    logic [7:0] aux;
    logic [7:0] rc1;
    logic [7:0] rc3;
  } rdc_preset_t;

endpackage

// ==== rdc_rx_cmd_ctrl.sv ====
// receiver side direct command control with APB register access
// assumes synchronous inputs, a 40 MHz clock and an analog front end that answers
// the converter start and squelch requests on the status inputs
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "rdc_defines.svh"

module rdc_rx_cmd_ctrl #(
  parameter int unsigned P_SQUELCH_CYC = `RDC_SQUELCH_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // front end status
  input wire logic i_osc_stable,
  input wire logic i_mrt_running,
  input wire logic i_adc_valid,
  input wire logic [7:0] i_adc_data,
  input wire logic i_squelch_done,
  // receiver control
  output logic o_rx_on,
  output logic o_framing_en,
  output logic o_mrt_reset,
  // measurement control
  output logic o_tx_on,
  output logic o_ampl_det_en,
  output logic o_adc_abs_mode,
  output logic o_adc_start,
  // gain and squelch control
  output logic o_squelch_active,
  output logic o_squelch_clear,
  output logic o_agc_init,
  output logic o_gain_load,
  output logic [7:0] o_gain_reduction,
  // command termination event
  output logic o_cmd_done
);

  localparam int unsigned MEAS_CYC = `RDC_MEAS_CYC;

  rdc_pkg::rdc_state_t state_q;
  logic [7:0] op_ctrl_q;
  logic [7:0] mode_q;
  logic [7:0] bitrate_q;
  logic [7:0] aux_q;
  logic [7:0] rc1_q;
  logic [7:0] rc3_q;
  logic [7:0] rc4_q;
  logic [7:0] adc_q;
  logic mask_cmd_q;
  logic rx_on_q;
  logic mrt_reset_q;
  logic meas_busy_q;
  logic squelch_q;
  logic done_q;
  logic squelch_clear_q;
  logic gain_load_q;
  logic adc_start_q;
  logic [7:0] gain_q;
  logic [14:0] cnt_q;
  logic [31:0] prdata_q;

  logic setup;
  logic wr_acc;
  logic mapped;
  logic cmd_wr;
  logic [7:0] cmd;
  logic idle;
  logic en_ok;
  logic rx_en;
  logic preset_acc;
  logic mask_acc;
  logic unmask_acc;
  logic meas_acc;
  logic squelch_acc;
  logic gain_acc;
  logic nfc_act;
  logic mask_d;
  rdc_pkg::rdc_preset_t preset;

  // index decode, also used by the read mux
  function automatic logic idx_hit(input logic [7:0] addr, input logic [5:0] idx);
    idx_hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] lp_sel(input logic [2:0] mode, input logic [1:0] rate);
    if (mode == `RDC_MODE_VICINITY) begin
      lp_sel = `RDC_LP_VICINITY;
    end else begin
      case (rate)
        `RDC_RATE_106: lp_sel = `RDC_LP_106;
        `RDC_RATE_212: lp_sel = `RDC_LP_212;
        `RDC_RATE_424: lp_sel = `RDC_LP_424;
        default: lp_sel = `RDC_LP_848;
      endcase
    end
  endfunction

  function automatic logic [2:0] zero_sel(input logic [2:0] mode, input logic [1:0] rate);
    if (mode == `RDC_MODE_ISOB || mode == `RDC_MODE_TYPEF) begin
      zero_sel = `RDC_ZERO_SUBC;
    end else if (rate == `RDC_RATE_848) begin
      zero_sel = `RDC_ZERO_848;
    end else begin
      zero_sel = `RDC_ZERO_DEFAULT;
    end
  endfunction

  // apb decode
  assign setup = i_psel && !i_penable;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign mapped = idx_hit(i_paddr, `RDC_IDX_CMD) || idx_hit(i_paddr, `RDC_IDX_OP_CTRL) ||
                  idx_hit(i_paddr, `RDC_IDX_MODE) || idx_hit(i_paddr, `RDC_IDX_BITRATE) ||
                  idx_hit(i_paddr, `RDC_IDX_AUX) || idx_hit(i_paddr, `RDC_IDX_RC1) ||
                  idx_hit(i_paddr, `RDC_IDX_RC3) || idx_hit(i_paddr, `RDC_IDX_RC4) ||
                  idx_hit(i_paddr, `RDC_IDX_ADC) || idx_hit(i_paddr, `RDC_IDX_STAT);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign o_prdata = prdata_q;

  assign cmd_wr = wr_acc && idx_hit(i_paddr, `RDC_IDX_CMD);
  assign cmd = i_pwdata[7:0];
  // non-chainable commands keep the block busy; anything but the gain reset sent meanwhile is dropped
  assign idle = (state_q == rdc_pkg::RDC_ST_IDLE);
  assign en_ok = op_ctrl_q[`RDC_OP_EN] && i_osc_stable;
  assign rx_en = op_ctrl_q[`RDC_OP_RX_EN];
  assign nfc_act = (mode_q[2:0] == `RDC_MODE_NFC_INIT) || (mode_q[2:0] == `RDC_MODE_NFC_TGT);

  // acceptance conditions
  assign preset_acc = cmd_wr && idle && cmd == `RDC_CMD_PRESET;
  assign mask_acc = cmd_wr && idle && cmd == `RDC_CMD_MASK && rx_en;
  assign unmask_acc = cmd_wr && idle && cmd == `RDC_CMD_UNMASK && rx_en;
  assign meas_acc = cmd_wr && idle && cmd == `RDC_CMD_MEAS_AMP && en_ok;
  assign gain_acc = cmd_wr && cmd == `RDC_CMD_GAIN_RST && en_ok;
  // accepted only with tx and rx enabled and while rx on is low; otherwise dropped
  assign squelch_acc = cmd_wr && idle && cmd == `RDC_CMD_SQUELCH && rx_en &&
                       op_ctrl_q[`RDC_OP_TX_EN] && !rx_on_q;

  // preset values
  always_comb begin
    preset.op_ctrl = op_ctrl_q;
    preset.aux = aux_q;
    preset.rc1 = rc1_q;
    preset.rc3 = rc3_q;
    preset.op_ctrl[`RDC_OP_RX_CHN] = nfc_act ? 1'b1 : op_ctrl_q[`RDC_OP_RX_CHN];
    if (mode_q[`RDC_MODE_TARGET] || nfc_act) begin
      preset.op_ctrl[`RDC_OP_TX_EN] = 1'b0;
    end
    preset.aux[`RDC_AUX_TX_MOD_TYPE] = !((mode_q[2:0] == `RDC_MODE_ISOA) ||
        (nfc_act && bitrate_q[5:4] == `RDC_RATE_106));
    preset.aux[`RDC_AUX_FIELD_DET_ON] = nfc_act;
    if (nfc_act) begin
      preset.rc1[`RDC_RC1_CHANNEL] = 1'b0;
    end
    // every supported rx rate is at or below fc/16
    preset.rc1[`RDC_RC1_AM_DEMOD] = 1'b0;
    preset.rc1[`RDC_RC1_LP_HI:`RDC_RC1_LP_LO] = lp_sel(mode_q[2:0], bitrate_q[1:0]);
    preset.rc1[`RDC_RC1_ZERO_HI:`RDC_RC1_ZERO_LO] =
        zero_sel(mode_q[2:0], bitrate_q[1:0]);
    preset.rc3[`RDC_RC3_CLIP] = nfc_act;
    preset.rc3[`RDC_RC3_FORCED_GAIN] = nfc_act;
  end

  // software registers; preset overrides the affected fields
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_ctrl_q <= `RDC_RST_OP_CTRL;
      mode_q <= `RDC_RST_MODE;
      bitrate_q <= `RDC_RST_BITRATE;
      aux_q <= `RDC_RST_AUX;
      rc1_q <= `RDC_RST_RC1;
      rc3_q <= `RDC_RST_RC3;
      rc4_q <= `RDC_RST_RC4;
    end else if (preset_acc) begin
      op_ctrl_q <= preset.op_ctrl;
      aux_q <= preset.aux;
      rc1_q <= preset.rc1;
      rc3_q <= preset.rc3;
    end else if (wr_acc) begin
      if (idx_hit(i_paddr, `RDC_IDX_OP_CTRL)) op_ctrl_q <= i_pwdata[7:0];
      if (idx_hit(i_paddr, `RDC_IDX_MODE)) mode_q <= i_pwdata[7:0];
      if (idx_hit(i_paddr, `RDC_IDX_BITRATE)) bitrate_q <= i_pwdata[7:0];
      if (idx_hit(i_paddr, `RDC_IDX_AUX)) aux_q <= i_pwdata[7:0];
      if (idx_hit(i_paddr, `RDC_IDX_RC1)) rc1_q <= i_pwdata[7:0];
      if (idx_hit(i_paddr, `RDC_IDX_RC3)) rc3_q <= i_pwdata[7:0];
      if (idx_hit(i_paddr, `RDC_IDX_RC4)) rc4_q <= i_pwdata[7:0];
    end
  end

  // read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= 32'h0000_0000;
      if (idx_hit(i_paddr, `RDC_IDX_OP_CTRL)) prdata_q[7:0] <= op_ctrl_q;
      if (idx_hit(i_paddr, `RDC_IDX_MODE)) prdata_q[7:0] <= mode_q;
      if (idx_hit(i_paddr, `RDC_IDX_BITRATE)) prdata_q[7:0] <= bitrate_q;
      if (idx_hit(i_paddr, `RDC_IDX_AUX)) prdata_q[7:0] <= aux_q;
      if (idx_hit(i_paddr, `RDC_IDX_RC1)) prdata_q[7:0] <= rc1_q;
      if (idx_hit(i_paddr, `RDC_IDX_RC3)) prdata_q[7:0] <= rc3_q;
      if (idx_hit(i_paddr, `RDC_IDX_RC4)) prdata_q[7:0] <= rc4_q;
      if (idx_hit(i_paddr, `RDC_IDX_ADC)) prdata_q[7:0] <= adc_q;
      if (idx_hit(i_paddr, `RDC_IDX_STAT)) begin
        prdata_q[`RDC_STAT_MEAS_BUSY] <= meas_busy_q;
        prdata_q[`RDC_STAT_SQUELCH] <= squelch_q;
        prdata_q[`RDC_STAT_RX_ON] <= rx_on_q;
        prdata_q[`RDC_STAT_MASK_CMD] <= mask_cmd_q;
      end
    end
  end

  // receive masking
  always_comb begin
    mask_d = mask_cmd_q;
    if (mask_acc) mask_d = 1'b1;
    if (unmask_acc) mask_d = 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mask_cmd_q <= 1'b0;
      rx_on_q <= 1'b0;
      mrt_reset_q <= 1'b0;
    end else begin
      mask_cmd_q <= mask_d;
      mrt_reset_q <= unmask_acc && i_mrt_running;
      // the timer still reads running the cycle after its reset, so that cycle is ignored
      rx_on_q <= rx_en && !(mask_d ||
          (i_mrt_running && !unmask_acc && !mrt_reset_q));
    end
  end

  assign o_rx_on = rx_on_q;
  assign o_framing_en = rx_on_q;
  assign o_mrt_reset = mrt_reset_q;

  // measurement and squelch sequencer
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= rdc_pkg::RDC_ST_IDLE;
      cnt_q <= 15'h0000;
      adc_q <= 8'h00;
      done_q <= 1'b0;
      adc_start_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      adc_start_q <= 1'b0;
      case (state_q)
        rdc_pkg::RDC_ST_IDLE: begin
          cnt_q <= 15'h0000;
          if (meas_acc) begin
            state_q <= rdc_pkg::RDC_ST_MEAS_WAIT;
            adc_start_q <= 1'b1;
          end else if (squelch_acc) begin
            state_q <= rdc_pkg::RDC_ST_SQUELCH;
          end
        end
        rdc_pkg::RDC_ST_MEAS_WAIT: begin
          cnt_q <= cnt_q + 15'h0001;
          // one count is 13.02 mVpp on the inputs; scaling lives in the detector
          // a silent converter still ends the command in time, result left as is
          if (i_adc_valid || cnt_q == 15'(MEAS_CYC - 2)) begin
            if (i_adc_valid) adc_q <= i_adc_data;
            state_q <= rdc_pkg::RDC_ST_IDLE;
            done_q <= 1'b1;
          end
        end
        rdc_pkg::RDC_ST_SQUELCH: begin
          cnt_q <= cnt_q + 15'h0001;
          if (gain_acc || i_squelch_done || cnt_q == 15'(P_SQUELCH_CYC - 1)) begin
            state_q <= rdc_pkg::RDC_ST_IDLE;
          end
        end
        default: state_q <= rdc_pkg::RDC_ST_IDLE;
      endcase
    end
  end

  assign meas_busy_q = (state_q == rdc_pkg::RDC_ST_MEAS_WAIT);
  assign squelch_q = (state_q == rdc_pkg::RDC_ST_SQUELCH);
  assign o_tx_on = op_ctrl_q[`RDC_OP_TX_EN] || meas_busy_q;
  assign o_ampl_det_en = meas_busy_q;
  assign o_adc_abs_mode = meas_busy_q;
  assign o_adc_start = adc_start_q;
  assign o_squelch_active = squelch_q;
  assign o_cmd_done = done_q;

  // gain reset
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gain_load_q <= 1'b0;
      squelch_clear_q <= 1'b0;
      gain_q <= 8'h00;
    end else begin
      gain_load_q <= gain_acc;
      squelch_clear_q <= gain_acc;
      if (gain_acc) gain_q <= rc4_q;
    end
  end

  assign o_gain_load = gain_load_q;
  assign o_agc_init = gain_load_q;
  assign o_squelch_clear = squelch_clear_q;
  assign o_gain_reduction = gain_q;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_meas_start;
    meas_acc ##1 meas_busy_q;
  endsequence

  sequence s_meas_end;
    o_cmd_done && !meas_busy_q;
  endsequence

  a_mask_forces_off: assert property (mask_acc |=> !o_rx_on && !o_framing_en)
    else $error("mask did not drop rx on");
  a_timer_mask_or: assert property (i_mrt_running && !unmask_acc && !mrt_reset_q
    |=> !o_rx_on)
    else $error("running mask timer left rx on");
  a_unmask_rx_on: assert property (unmask_acc && !i_mrt_running && !mask_acc
    |=> o_rx_on && o_framing_en)
    else $error("unmask did not raise rx on");
  a_unmask_timer_reset: assert property (unmask_acc && i_mrt_running
    |=> o_mrt_reset ##1 !o_mrt_reset)
    else $error("unmask did not reset mask timer");
  a_mask_needs_rx: assert property (cmd_wr && cmd == `RDC_CMD_MASK && !rx_en
    |=> $stable(mask_cmd_q))
    else $error("mask accepted with receiver off");
  a_meas_bounded: assert property (s_meas_start |-> ##[0:1000] s_meas_end)
    else $error("amplitude measurement overran");
  a_meas_gate: assert property (cmd_wr && cmd == `RDC_CMD_MEAS_AMP && !en_ok && idle
    |=> idle && !o_adc_start)
    else $error("measurement started without enable");
  a_preset_nfc: assert property (preset_acc && nfc_act |=> aux_q[`RDC_AUX_FIELD_DET_ON]
    && rc3_q[1:0] == 2'h3 && !rc1_q[`RDC_RC1_CHANNEL] && !op_ctrl_q[`RDC_OP_TX_EN])
    else $error("nfc preset bits wrong");
  a_preset_ook: assert property (preset_acc && mode_q[2:0] == `RDC_MODE_ISOA
    |=> !aux_q[`RDC_AUX_TX_MOD_TYPE] && !rc1_q[`RDC_RC1_AM_DEMOD])
    else $error("type A preset not ook");
  a_squelch_no_done: assert property (squelch_q |-> !o_cmd_done)
    else $error("squelch raised termination");
  a_gain_load: assert property (gain_acc |=> o_gain_load && o_squelch_clear
    && o_gain_reduction == $past(rc4_q) && !o_cmd_done)
    else $error("gain reset did not load gain");

endmodule // rdc_rx_cmd_ctrl

// ==== rdc_fe_model.sv ====
// front end stand-in: answers converter start and squelch runs
// assumes one clock shared with rdc_rx_cmd_ctrl; a delay of 0 never answers
`timescale 1ns/1ps
module rdc_fe_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // from the block
  input wire logic i_adc_start,
  input wire logic i_squelch_active,
  // bench settings
  input wire logic [7:0] i_adc_dly,
  input wire logic [7:0] i_sq_dly,
  input wire logic [7:0] i_amp,
  // to the block
  output logic o_adc_valid,
  output logic [7:0] o_adc_data,
  output logic o_squelch_done
);
  logic [7:0] adc_cnt_q;
  logic [7:0] sq_cnt_q;
  logic sq_seen_q;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      adc_cnt_q <= 8'h00;
      o_adc_valid <= 1'b0;
      o_adc_data <= 8'h5A;
    end else begin
      adc_cnt_q <= i_adc_start ? i_adc_dly : adc_cnt_q - 8'(adc_cnt_q != 8'h00);
      o_adc_valid <= (adc_cnt_q == 8'h01);
      // data only valid with the strobe; otherwise it keeps toggling
      o_adc_data <= (adc_cnt_q == 8'h01) ? i_amp : ~o_adc_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sq_cnt_q <= 8'h00;
      sq_seen_q <= 1'b0;
      o_squelch_done <= 1'b0;
    end else begin
      sq_seen_q <= i_squelch_active;
      if (i_squelch_active && !sq_seen_q) begin
        sq_cnt_q <= i_sq_dly;
      end else if (sq_cnt_q != 8'h00) begin
        sq_cnt_q <= sq_cnt_q - 8'h01;
      end
      o_squelch_done <= (sq_cnt_q == 8'h01) && i_squelch_active;
    end
  end
endmodule // rdc_fe_model

// ==== rdc_rx_cmd_ctrl_bench.sv ====
// self-checking bench of rdc_rx_cmd_ctrl, APB master plus front end model
// assumes zero-wait APB slave and the register indices of rdc_defines.svh
`timescale 1ns/1ps
`include "rdc_defines.svh"
module rdc_rx_cmd_ctrl_bench;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, osc_ok, mrt_run;
  logic [7:0] paddr, amp, adc_dly, sq_dly, adc_data, gain, ea, g;
  logic [31:0] pwdata, prdata;
  logic adc_valid, sq_done, rx_on, frm_en, mrt_rst, tx_on, det_en, abs_md, adc_start;
  logic sq_act, sq_clr, agc_init, gain_ld, cmd_done;
  logic [16:0] notes[$];
  logic [16:0] nt;
  int error_cnt = 0;
  int checks = 0;
  integer seed = 32'h0cec;
  int n_start = 0;
  int n_done = 0;
  int n_mrt = 0;
  int n_agc = 0;
  int k, d0;
  logic [7:0] pm[5] = '{8'h00, 8'h01, 8'h03, 8'h85, 8'h00};
  logic [7:0] pr[5] = '{8'h00, 8'h11, 8'h22, 8'h00, 8'h33};
  logic [7:0] pa[5] = '{8'h00, 8'h20, 8'h30, 8'h10, 8'h00};
  logic [7:0] pk[5] = '{8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'h7F};
  logic [7:0] p1[5] = '{8'h00, 8'h0E, 8'h10, 8'h00, 8'h23};
  logic [7:0] p3[5] = '{8'h00, 8'h00, 8'h03, 8'h03, 8'h00};
  logic [7:0] po[5] = '{8'h80, 8'h80, 8'h28, 8'h28, 8'h80};

  rdc_rx_cmd_ctrl #(.P_SQUELCH_CYC(50)) dut (.i_ref_clk(clk), .i_reset_n(rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_osc_stable(osc_ok), .i_mrt_running(mrt_run), .i_adc_valid(adc_valid),
    .i_adc_data(adc_data), .i_squelch_done(sq_done), .o_rx_on(rx_on),
    .o_framing_en(frm_en), .o_mrt_reset(mrt_rst), .o_tx_on(tx_on),
    .o_ampl_det_en(det_en), .o_adc_abs_mode(abs_md), .o_adc_start(adc_start),
    .o_squelch_active(sq_act), .o_squelch_clear(sq_clr), .o_agc_init(agc_init),
    .o_gain_load(gain_ld), .o_gain_reduction(gain), .o_cmd_done(cmd_done));

  rdc_fe_model fe (.i_ref_clk(clk), .i_reset_n(rst_n), .i_adc_start(adc_start),
    .i_squelch_active(sq_act), .i_adc_dly(adc_dly), .i_sq_dly(sq_dly), .i_amp(amp),
    .o_adc_valid(adc_valid), .o_adc_data(adc_data), .o_squelch_done(sq_done));

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // request held from setup until pready is sampled high
  task automatic apb(input logic [5:0] idx, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, idx, 2'b00, 24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      give_verdict();
    end
    {psel, penable} <= 2'b00;
  endtask

  task automatic rd(input logic [5:0] i, input logic [7:0] m, input logic [7:0] e,
                    input logic err);
    notes.push_back({err, m, e});
    apb(i, 1'b0, 8'h00);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic waitc(ref int c, input int t, input int lim);
    int n;
    for (n = 0; n < lim && c < t; n++) @(posedge clk);
    if (c < t) begin
      error_cnt++;
      give_verdict();
    end
  endtask

  // outcome watcher: read data against the oldest note, pulses counted
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      nt = notes.pop_front();
      chk({7'h0, pslverr, prdata[7:0] & nt[15:8]}, {7'h0, nt[16], nt[7:0]});
    end
    if (adc_start) begin
      n_start++;
      chk({tx_on, det_en, abs_md}, 3'b111);
    end
    if (agc_init) begin
      n_agc++;
      chk({sq_clr, gain_ld}, 2'b11);
    end
    n_done += int'(cmd_done);
    n_mrt += int'(mrt_rst);
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rst_n, osc_ok, mrt_run, amp, adc_dly, sq_dly} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(`RDC_IDX_OP_CTRL, 8'hFF, `RDC_RST_OP_CTRL, 0);
    rd(`RDC_IDX_RC3, 8'hFF, `RDC_RST_RC3, 0);
    rd(6'h3F, 8'hFF, 8'h00, 1);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      apb(`RDC_IDX_OP_CTRL, 1, 8'h88);
      apb(`RDC_IDX_RC1, 1, 8'hFF);
      apb(`RDC_IDX_MODE, 1, pm[i]);
      apb(`RDC_IDX_BITRATE, 1, pr[i]);
      apb(`RDC_IDX_CMD, 1, `RDC_CMD_PRESET);
      rd(`RDC_IDX_AUX, 8'h30, pa[i], 0);
      rd(`RDC_IDX_RC1, pk[i], p1[i], 0);
      rd(`RDC_IDX_RC3, 8'h03, p3[i], 0);
      rd(`RDC_IDX_OP_CTRL, po[i], po[i] & 8'hA0, 0);
    end
    $display("test preset done");
    apb(`RDC_IDX_OP_CTRL, 1, 8'hC0);
    apb(`RDC_IDX_CMD, 1, `RDC_CMD_UNMASK);
    tick(2);
    chk({rx_on, frm_en}, 2'b11);
    apb(`RDC_IDX_CMD, 1, `RDC_CMD_MASK);
    tick(2);
    chk({rx_on, frm_en}, 2'b00);
    rd(`RDC_IDX_STAT, 8'h0C, 8'h08, 0);
    mrt_run <= 1'b1;
    k = n_mrt;
    apb(`RDC_IDX_CMD, 1, `RDC_CMD_UNMASK);
    // timer stand-in stops one cycle after its reset pulse, as a real timer would
    @(posedge clk);
    mrt_run <= 1'b0;
    tick(1);
    chk({rx_on, 7'(n_mrt - k)}, 8'h81);
    // running timer alone masks the receiver
    @(posedge clk);
    mrt_run <= 1'b1;
    tick(2);
    chk({rx_on, frm_en}, 2'b00);
    @(posedge clk);
    mrt_run <= 1'b0;
    apb(`RDC_IDX_OP_CTRL, 1, 8'h80);
    apb(`RDC_IDX_CMD, 1, `RDC_CMD_MASK);
    rd(`RDC_IDX_STAT, 8'h08, 8'h00, 0);
    $display("test mask done");
    k = n_start;
    apb(`RDC_IDX_CMD, 1, `RDC_CMD_MEAS_AMP);
    tick(5);
    chk(16'(n_start - k), 16'h0);
    @(posedge clk);
    osc_ok <= 1'b1;
    ea = 8'h00;
    for (int i = 0; i < 4; i++) begin
      // first pass carries the full-scale code of a 3 Vpp input
      amp <= (i == 0) ? `RDC_AMPL_FULL_CODE : 8'($random(seed));
      adc_dly <= (i == 3) ? 8'h00 : 8'h08 + 8'($random(seed) & 8'h3F);
      tick(1);
      if (i != 3) ea = amp;
      k = n_start;
      d0 = n_done;
      apb(`RDC_IDX_CMD, 1, `RDC_CMD_MEAS_AMP);
      apb(`RDC_IDX_CMD, 1, `RDC_CMD_MEAS_AMP);
      waitc(n_done, d0 + 1, 1000);
      chk(16'(n_start - k), 16'h1);
      rd(`RDC_IDX_ADC, 8'hFF, ea, 0);
    end
    $display("test measure done");
    d0 = n_done;
    apb(`RDC_IDX_OP_CTRL, 1, 8'hC8);
    apb(`RDC_IDX_CMD, 1, `RDC_CMD_UNMASK);
    apb(`RDC_IDX_CMD, 1, `RDC_CMD_SQUELCH);
    tick(3);
    chk(sq_act, 1'b0);
    apb(`RDC_IDX_CMD, 1, `RDC_CMD_MASK);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      sq_dly <= (i == 0) ? 8'h14 : 8'h00;
      apb(`RDC_IDX_CMD, 1, `RDC_CMD_SQUELCH);
      tick(2);
      chk(sq_act, 1'b1);
      if (i == 2) begin
        g = 8'($random(seed));
        apb(`RDC_IDX_RC4, 1, g);
        k = n_agc;
        apb(`RDC_IDX_CMD, 1, `RDC_CMD_GAIN_RST);
        tick(2);
        chk({sq_act, 7'(n_agc - k), gain}, {8'h01, g});
      end
      tick(i == 0 ? 22 : 52);
      chk(sq_act, 1'b0);
    end
    @(posedge clk);
    osc_ok <= 1'b0;
    k = n_agc;
    apb(`RDC_IDX_CMD, 1, `RDC_CMD_GAIN_RST);
    tick(3);
    chk(16'(n_agc - k), 16'h0);
    chk(16'(n_done - d0), 16'h0);
    $display("test squelch done");
    give_verdict();
  end
endmodule // rdc_rx_cmd_ctrl_bench
